// File: include/rx_monitor_regs.vh
// Register map and constants for the receive channel byte monitor.
// Assumes a 32-bit AXI4-Lite slave with one aligned word per register.
`ifndef RX_MONITOR_REGS_VH
`define RX_MONITOR_REGS_VH

// Register index and byte address of the common control register
`define CTRL_FIVE_IDX 8'h2B
`define CTRL_FIVE_ADDR 10'h0AC
// Monitor register index; its byte address is four times the index
`define MON_BYTE_IDX 8'hAB
`define MON_BYTE_WADDR 10'h2AC
// Field positions
`define SEL_MSB 4
`define SEL_LSB 0
// Reset values
`define CTRL_FIVE_RST 8'h00
`define MON_BYTE_RST 8'h00
// Bits per timeslot and timeslots per frame
`define BITS_PER_SLOT 8
`define SLOTS_PER_FRAME 32
// AXI responses
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// File: hw/slot_capture.v
// Serial capture of one selected timeslot into a byte.
// Assumes clock-domain-clean inputs: bit strobe, slot number and bit index.
`timescale 1ns/1ns
`default_nettype none
`include "rx_monitor_regs.vh"

module slot_capture #(
	parameter SEL_W = 5
) (
	// Clock and reset
	input wire clk,
	input wire rst,
	// Receive stream, already synchronised
	input wire bit_stb,
	input wire data_bit,
	input wire [4:0] slot_num,
	input wire [2:0] bit_idx,
	// Selected slot and result
	input wire [SEL_W-1:0] sel,
	output reg [7:0] byte_out,
	output reg byte_stb
);

	reg [7:0] shift_r;
	wire hit;
	wire [7:0] shift_nxt;

	// Code is channel minus one, and channel n rides in slot n-1, so code equals slot
	assign hit = bit_stb && (slot_num == sel); // R5 R6
	// First bit lands in the top after eight shifts
	assign shift_nxt = {shift_r[6:0], data_bit}; // R3 R4

	// Shift in slot bits; publish after the eighth
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			shift_r <= `MON_BYTE_RST;
			byte_out <= `MON_BYTE_RST;
			byte_stb <= 1'b0;
		end else begin
			byte_stb <= 1'b0;
			if (hit) begin
				shift_r <= shift_nxt;
				if (bit_idx == 3'h7) begin
					byte_out <= shift_nxt; // R6
					byte_stb <= 1'b1;
				end
			end
		end
	end

endmodule
`default_nettype wire

// File: hw/rx_channel_monitor.v
// Receive channel byte monitor with an AXI4-Lite register port.
// Assumes the framer's serial data, slot and bit counters arrive from a foreign clock.
// Overview of operation
// (R1) Five-bit channel select in control bits 4:0
// (R2) Selected channel byte readable at offset AB
// (R3) First received bit goes to bit seven
// (R4) Last received bit goes to bit zero
// (R5) Channel n travels in timeslot n minus one
// (R6) Code is channel minus one; reload per frame
//
// Design decision made here: the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
`default_nettype none
`include "rx_monitor_regs.vh"

module rx_channel_monitor #(
	parameter ADDR_W = 10
) (
	// Clock and reset
	input wire CLK,
	input wire SYS_RST,
	// Framer receive stream (foreign timing)
	input wire RX_BIT_STB,
	input wire RX_DATA,
	input wire [4:0] RX_SLOT,
	input wire [2:0] RX_BIT_IDX,
	// AXI4-Lite write address
	input wire [ADDR_W-1:0] S_AXI_AWADDR,
	input wire S_AXI_AWVALID,
	output reg S_AXI_AWREADY,
	// AXI4-Lite write data
	input wire [31:0] S_AXI_WDATA,
	input wire [3:0] S_AXI_WSTRB,
	input wire S_AXI_WVALID,
	output reg S_AXI_WREADY,
	// AXI4-Lite write response
	output reg [1:0] S_AXI_BRESP,
	output reg S_AXI_BVALID,
	input wire S_AXI_BREADY,
	// AXI4-Lite read address
	input wire [ADDR_W-1:0] S_AXI_ARADDR,
	input wire S_AXI_ARVALID,
	output reg S_AXI_ARREADY,
	// AXI4-Lite read data
	output reg [31:0] S_AXI_RDATA,
	output reg [1:0] S_AXI_RRESP,
	output reg S_AXI_RVALID,
	input wire S_AXI_RREADY
);

	// Results of the shared register decode
	localparam [1:0] DEC_NONE = 2'h0;
	localparam [1:0] DEC_CTRL = 2'h1;
	localparam [1:0] DEC_MON = 2'h2;

	// Register decode shared by read and write paths
	function [1:0] decode;
		input [ADDR_W-1:0] a;
		begin
			if (a == `CTRL_FIVE_ADDR)
				decode = DEC_CTRL;
			else if (a == `MON_BYTE_WADDR)
				decode = DEC_MON;
			else
				decode = DEC_NONE;
		end
	endfunction

	// Two-flop synchronisers on every framer input
	reg [9:0] sync1_r;
	reg [9:0] sync2_r;
	always @(posedge CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			sync1_r <= 10'h000;
			sync2_r <= 10'h000;
		end else begin
			sync1_r <= {RX_BIT_STB, RX_DATA, RX_SLOT, RX_BIT_IDX};
			sync2_r <= sync1_r;
		end
	end

	// Strobe edge detect one cycle late: data, slot and bit index cross with the
	// strobe and may still be settling on its first synchronised cycle
	reg stb_d_r;
	reg stb_d2_r;
	wire stb_rise;
	always @(posedge CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			stb_d_r <= 1'b0;
			stb_d2_r <= 1'b0;
		end else begin
			stb_d_r <= sync2_r[9];
			stb_d2_r <= stb_d_r;
		end
	end
	// Needs the framer strobe high for at least two clocks
	assign stb_rise = stb_d_r & ~stb_d2_r;

	// Control register and monitor byte
	reg [7:0] ctrl_r;
	wire [7:0] mon_byte;

	slot_capture #(
		.SEL_W(5)
	) u_cap (
		.clk(CLK),
		.rst(SYS_RST),
		.bit_stb(stb_rise),
		.data_bit(sync2_r[8]),
		.slot_num(sync2_r[7:3]),
		.bit_idx(sync2_r[2:0]),
		.sel(ctrl_r[`SEL_MSB:`SEL_LSB]), // R1 R6
		.byte_out(mon_byte), // R2
		.byte_stb()
	);

	// Write channel: address and data latched independently, either order
	reg aw_full_r;
	reg w_full_r;
	reg [ADDR_W-1:0] aw_addr_r;
	reg [7:0] w_data_r;
	reg w_lane_r;
	wire do_write;
	// A pending pair waits while the previous answer is still unread
	assign do_write = aw_full_r && w_full_r && !S_AXI_BVALID;

	// Write address slot; ready is a one-cycle pulse accepting a waiting valid
	always @(posedge CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			aw_full_r <= 1'b0;
			aw_addr_r <= {ADDR_W{1'b0}};
			S_AXI_AWREADY <= 1'b0;
		end else begin
			// Kept low while an address waits, so none is overwritten
			S_AXI_AWREADY <= S_AXI_AWVALID && !aw_full_r && !S_AXI_AWREADY;
			if (S_AXI_AWVALID && S_AXI_AWREADY) begin
				aw_full_r <= 1'b1;
				aw_addr_r <= S_AXI_AWADDR;
			end else if (do_write) begin
				aw_full_r <= 1'b0;
			end
		end
	end

	// Write data slot; only the low byte lane is kept
	always @(posedge CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			w_full_r <= 1'b0;
			w_data_r <= 8'h00;
			w_lane_r <= 1'b0;
			S_AXI_WREADY <= 1'b0;
		end else begin
			S_AXI_WREADY <= S_AXI_WVALID && !w_full_r && !S_AXI_WREADY;
			if (S_AXI_WVALID && S_AXI_WREADY) begin
				w_full_r <= 1'b1;
				w_data_r <= S_AXI_WDATA[7:0];
				w_lane_r <= S_AXI_WSTRB[0];
			end else if (do_write) begin
				w_full_r <= 1'b0;
			end
		end
	end

	// Effect of the pending write, decoded from the latched address
	reg [1:0] bresp_nxt;
	reg ctrl_we;
	always @* begin
		bresp_nxt = `RESP_OKAY;
		ctrl_we = 1'b0;
		if (decode(aw_addr_r) == DEC_CTRL) begin
			// Byte-wide register: a write without the low lane changes nothing
			ctrl_we = w_lane_r; // R1
		end else if (decode(aw_addr_r) == DEC_MON) begin
			// Monitor is read-only; writes are ignored but answered
			bresp_nxt = `RESP_OKAY;
		end else begin
			bresp_nxt = `RESP_SLVERR;
		end
	end

	// Write response; stands until the master takes it
	always @(posedge CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			S_AXI_BVALID <= 1'b0;
			S_AXI_BRESP <= `RESP_OKAY;
		end else if (do_write) begin
			S_AXI_BVALID <= 1'b1;
			S_AXI_BRESP <= bresp_nxt;
		end else if (S_AXI_BVALID && S_AXI_BREADY) begin
			S_AXI_BVALID <= 1'b0;
		end
	end

	// Control register; bits 7:5 are stored and read back but take no part in the select
	always @(posedge CLK or posedge SYS_RST) begin
		if (SYS_RST)
			ctrl_r <= `CTRL_FIVE_RST;
		else if (do_write && ctrl_we)
			ctrl_r <= w_data_r; // R1
	end

	// Read data selection for the offered address
	reg [31:0] rdata_nxt;
	reg [1:0] rresp_nxt;
	always @* begin
		rdata_nxt = 32'h00000000;
		rresp_nxt = `RESP_OKAY;
		if (decode(S_AXI_ARADDR) == DEC_CTRL) begin
			rdata_nxt = {24'h000000, ctrl_r}; // R1
		end else if (decode(S_AXI_ARADDR) == DEC_MON) begin
			// Unused upper bits read as zero
			rdata_nxt = {24'h000000, mon_byte}; // R2 R3 R4
		end else begin
			rresp_nxt = `RESP_SLVERR;
		end
	end

	// Read address: one read at a time, so ready waits for the answer to be taken
	always @(posedge CLK or posedge SYS_RST) begin
		if (SYS_RST)
			S_AXI_ARREADY <= 1'b0;
		else
			S_AXI_ARREADY <= S_AXI_ARVALID && !S_AXI_ARREADY && !S_AXI_RVALID;
	end

	// Read answer the cycle after acceptance; stands until the master takes it
	always @(posedge CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			S_AXI_RVALID <= 1'b0;
			S_AXI_RDATA <= 32'h00000000;
			S_AXI_RRESP <= `RESP_OKAY;
		end else if (S_AXI_ARVALID && S_AXI_ARREADY) begin
			S_AXI_RVALID <= 1'b1;
			S_AXI_RDATA <= rdata_nxt;
			S_AXI_RRESP <= rresp_nxt;
		end else if (S_AXI_RVALID && S_AXI_RREADY) begin
			S_AXI_RVALID <= 1'b0;
		end
	end

endmodule
`default_nettype wire

// File: testbench/rx_monitor_asserts.sv
// Checker on the monitor's register port.
// Assumes a bind onto rx_channel_monitor.
`timescale 1ns/1ns
`default_nettype none
module rx_monitor_asserts #(
	parameter ADDR_W = 10
) (
	// Clock and reset
	input wire logic CLK,
	input wire logic SYS_RST,
	// Read side
	input wire logic S_AXI_ARVALID,
	input wire logic S_AXI_ARREADY,
	input wire logic S_AXI_RVALID,
	input wire logic S_AXI_RREADY,
	input wire logic [ADDR_W-1:0] S_AXI_ARADDR,
	input wire logic [31:0] S_AXI_RDATA,
	input wire logic [1:0] S_AXI_RRESP,
	// Write side
	input wire logic S_AXI_AWVALID,
	input wire logic S_AXI_AWREADY,
	input wire logic S_AXI_WVALID,
	input wire logic S_AXI_WREADY,
	input wire logic S_AXI_BVALID,
	input wire logic S_AXI_BREADY
);
	default clocking @(posedge CLK); endclocking
	default disable iff (SYS_RST);
	// Address taken on the read channel
	wire ar_go = S_AXI_ARVALID && S_AXI_ARREADY;
	mon_read_a: assert property (ar_go && S_AXI_ARADDR == 10'h2AC |=> S_AXI_RVALID &&
		S_AXI_RRESP == 2'h0 && S_AXI_RDATA[31:8] == 24'h0) else $error("monitor read");
	ctrl_read_a: assert property (ar_go && S_AXI_ARADDR == 10'h0AC |=> S_AXI_RVALID &&
		S_AXI_RRESP == 2'h0 && S_AXI_RDATA[31:8] == 24'h0) else $error("control read");
	unmapped_read_a: assert property (ar_go && S_AXI_ARADDR != 10'h0AC &&
		S_AXI_ARADDR != 10'h2AC |=> S_AXI_RRESP == 2'h2 && S_AXI_RDATA == 32'h0)
		else $error("unmapped read");
	ar_pulse_a: assert property (S_AXI_ARREADY |=> !S_AXI_ARREADY)
		else $error("read ready held");
	aw_pulse_a: assert property (S_AXI_AWREADY |=> !S_AXI_AWREADY)
		else $error("write address ready held");
	w_pulse_a: assert property (S_AXI_WREADY |=> !S_AXI_WREADY)
		else $error("write data ready held");
	read_done_a: assert property (S_AXI_RVALID && S_AXI_RREADY |=> !S_AXI_RVALID)
		else $error("read answer repeated");
	write_answer_a: assert property (S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID &&
		S_AXI_WREADY |-> ##[1:2] S_AXI_BVALID ##1 !S_AXI_BVALID) else $error("write answer");
endmodule
`default_nettype wire

// File: testbench/rx_framer_model.sv
// Receive framer model: 32 slots of 8 bits, first bit is the MSB.
// Assumes the bench gives a pattern; slot s carries pattern xor s.
`timescale 1ns/1ns
`default_nettype none
module rx_framer_model (
	// Clock, reset and pattern
	input wire logic CLK, SYS_RST,
	input wire logic [7:0] pat,
	// Serial stream
	output logic stb, dat,
	output logic [4:0] slot,
	output logic [2:0] idx
);
	logic [9:0] ph_r;
	logic [7:0] pat_r, v;
	// Four clocks a bit: strobe two high, two low; pattern only at frame start
	always @(posedge CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			ph_r <= 10'h000;
			pat_r <= 8'h00;
		end else begin
			ph_r <= ph_r + 10'h001;
			if (ph_r == 10'h3FF) pat_r <= pat;
		end
	end
	assign slot = ph_r[9:5];
	assign idx = ph_r[4:2];
	assign stb = ~ph_r[1];
	assign v = pat_r ^ {3'h0, slot};
	// Off-strobe the line shows the inverse, so stale data cannot pass
	assign dat = stb ? v[3'h7 - idx] : ~v[3'h7 - idx];
endmodule
`default_nettype wire

// File: testbench/test_receive_channel_byte_monitor.sv
// Self-checking bench for the receive channel byte monitor.
// Assumes a 25 MHz clock and the framer model on the serial side.
`timescale 1ns/1ns
`default_nettype none
module test_receive_channel_byte_monitor;
	logic CLK = 1'b0, SYS_RST = 1'b1, RX_BIT_STB, RX_DATA;
	logic [4:0] RX_SLOT;
	logic [2:0] RX_BIT_IDX;
	logic [9:0] S_AXI_AWADDR = 10'h000, S_AXI_ARADDR = 10'h000;
	logic S_AXI_AWVALID = 1'b0, S_AXI_WVALID = 1'b0, S_AXI_BREADY = 1'b0;
	logic S_AXI_ARVALID = 1'b0, S_AXI_RREADY = 1'b0;
	logic S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID, S_AXI_ARREADY, S_AXI_RVALID;
	logic [31:0] S_AXI_WDATA = 32'h0, S_AXI_RDATA, d;
	logic [3:0] S_AXI_WSTRB = 4'hF;
	logic [1:0] S_AXI_BRESP, S_AXI_RRESP;
	logic [7:0] pat = 8'h00;
	int mismatches = 0, checked = 0, cyc = 0;
	always #20 CLK = ~CLK;
	rx_channel_monitor u_rx_channel_monitor (
		.CLK(CLK),
		.SYS_RST(SYS_RST),
		.RX_BIT_STB(RX_BIT_STB),
		.RX_DATA(RX_DATA),
		.RX_SLOT(RX_SLOT),
		.RX_BIT_IDX(RX_BIT_IDX),
		.S_AXI_AWADDR(S_AXI_AWADDR),
		.S_AXI_AWVALID(S_AXI_AWVALID),
		.S_AXI_AWREADY(S_AXI_AWREADY),
		.S_AXI_WDATA(S_AXI_WDATA),
		.S_AXI_WSTRB(S_AXI_WSTRB),
		.S_AXI_WVALID(S_AXI_WVALID),
		.S_AXI_WREADY(S_AXI_WREADY),
		.S_AXI_BRESP(S_AXI_BRESP),
		.S_AXI_BVALID(S_AXI_BVALID),
		.S_AXI_BREADY(S_AXI_BREADY),
		.S_AXI_ARADDR(S_AXI_ARADDR),
		.S_AXI_ARVALID(S_AXI_ARVALID),
		.S_AXI_ARREADY(S_AXI_ARREADY),
		.S_AXI_RDATA(S_AXI_RDATA),
		.S_AXI_RRESP(S_AXI_RRESP),
		.S_AXI_RVALID(S_AXI_RVALID),
		.S_AXI_RREADY(S_AXI_RREADY)
	);
	rx_framer_model u_rx_framer_model (.CLK(CLK), .SYS_RST(SYS_RST), .pat(pat),
		.stb(RX_BIT_STB), .dat(RX_DATA), .slot(RX_SLOT), .idx(RX_BIT_IDX));
	function logic [31:0] mon_exp(input logic [7:0] p, input logic [4:0] s);
		return {24'h0, p ^ {3'h0, s}};
	endfunction
	task chk(input logic [33:0] g, e);
		checked++;
		if (g !== e) begin
			mismatches++;
			$display("BAD %0t got %h want %h", $time, g, e);
		end
	endtask
	task chk_resp(input logic [1:0] g, e);
		checked++;
		if (g !== e) begin
			mismatches++;
			$display("BAD %0t write response %h want %h", $time, g, e);
		end
	endtask
	// Both write channels offered together, each dropped once taken
	task wr(input logic [9:0] a, input logic [31:0] v, input logic [1:0] r);
		@(posedge CLK);
		S_AXI_AWADDR <= a;
		S_AXI_WDATA <= v;
		S_AXI_AWVALID <= 1'b1;
		S_AXI_WVALID <= 1'b1;
		S_AXI_BREADY <= 1'b1;
		do begin
			@(posedge CLK);
			if (S_AXI_AWREADY) S_AXI_AWVALID <= 1'b0;
			if (S_AXI_WREADY) S_AXI_WVALID <= 1'b0;
		end while (!S_AXI_BVALID);
		S_AXI_BREADY <= 1'b0;
		chk_resp(S_AXI_BRESP, r);
	endtask
	task rd(input logic [9:0] a, input logic [31:0] v, input logic [1:0] r);
		@(posedge CLK);
		S_AXI_ARADDR <= a;
		S_AXI_ARVALID <= 1'b1;
		S_AXI_RREADY <= 1'b1;
		do begin
			@(posedge CLK);
			if (S_AXI_ARREADY) S_AXI_ARVALID <= 1'b0;
		end while (!S_AXI_RVALID);
		S_AXI_RREADY <= 1'b0;
		chk({S_AXI_RRESP, S_AXI_RDATA}, {r, v});
	endtask
	initial begin
		void'($urandom(18384));
		repeat (12) @(posedge CLK);
		SYS_RST <= 1'b0;
		rd(10'h0AC, 32'h0, 2'h0);
		rd(10'h2AC, 32'h0, 2'h0);
		rd(10'h010, 32'h0, 2'h2);
		wr(10'h010, 32'h5A, 2'h2);
		// A write without the low lane must leave the control byte alone
		S_AXI_WSTRB <= 4'hE;
		wr(10'h0AC, 32'h15, 2'h0);
		S_AXI_WSTRB <= 4'hF;
		rd(10'h0AC, 32'h0, 2'h0);
		$display("test reset done");
		// Channel 1, channel 32, then random channels and spare bits
		for (int i = 0; i < 6; i++) begin
			d = (i == 0) ? 32'h0 : (i == 1) ? 32'h1F : $urandom;
			pat <= 8'($urandom);
			wr(10'h0AC, d, 2'h0);
			rd(10'h0AC, {24'h0, d[7:0]}, 2'h0);
			repeat (2200) @(posedge CLK);
			rd(10'h2AC, mon_exp(pat, d[4:0]), 2'h0);
			wr(10'h2AC, 32'hFF, 2'h0);
			rd(10'h2AC, mon_exp(pat, d[4:0]), 2'h0);
			$display("test %0d done", i);
		end
		summarize();
	end
	// Ceiling well above six channel tests of two frames each
	always @(posedge CLK) begin
		cyc <= cyc + 1;
		if (cyc == 40000) begin
			mismatches++;
			summarize();
		end
	end
	task summarize();
		$display("checked %0d mismatches %0d", checked, mismatches);
		if (mismatches == 0 && checked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
endmodule
bind rx_channel_monitor rx_monitor_asserts #(.ADDR_W(ADDR_W)) u_rx_monitor_asserts (
	.CLK(CLK),
	.SYS_RST(SYS_RST),
	.S_AXI_ARVALID(S_AXI_ARVALID),
	.S_AXI_ARREADY(S_AXI_ARREADY),
	.S_AXI_RVALID(S_AXI_RVALID),
	.S_AXI_RREADY(S_AXI_RREADY),
	.S_AXI_ARADDR(S_AXI_ARADDR),
	.S_AXI_RDATA(S_AXI_RDATA),
	.S_AXI_RRESP(S_AXI_RRESP),
	.S_AXI_AWVALID(S_AXI_AWVALID),
	.S_AXI_AWREADY(S_AXI_AWREADY),
	.S_AXI_WVALID(S_AXI_WVALID),
	.S_AXI_WREADY(S_AXI_WREADY),
	.S_AXI_BVALID(S_AXI_BVALID),
	.S_AXI_BREADY(S_AXI_BREADY)
);
`default_nettype wire
